// file: src/rsi_defs.svh
// constants of the reset-state initializer: register map, reset values
// assumes an 8-bit register port and the 50 MHz system clock
//
// Operation
// [R1] power-on clears timeout and power-down flags
// [R2] pin or low-voltage reset keeps both flags
// [R3] watchdog reset when running sets timeout only
// [R4] watchdog reset in idle/sleep sets both flags
// [R5] sleep entry and watchdog clear update flags
// [R6] power-on: counter zero, stack pointer top
// [R7] power-on disables every interrupt enable
// [R8] watchdog and time base cleared, watchdog restarts
// [R9] timer control and count return to zero
// [R10] port direction and data load all ones
// [R11] low-power watchdog reset keeps most, clears counter
// [R12] low-power watchdog reset clears counter, stack pointer
// [R13] direction bit zero output, one input
// [R14] timeout at status bit 5, power-down bit 4
`ifndef RSI_DEFS_SVH
`define RSI_DEFS_SVH

`define RSI_AW            5
`define RSI_DW            8
`define RSI_NPORTS        6
`define RSI_SPW           4

`define RSI_ADDR_STATUS   5'h00
`define RSI_ADDR_PCL      5'h01
`define RSI_ADDR_SP       5'h02
`define RSI_ADDR_INTEN    5'h03
`define RSI_ADDR_WDT      5'h04
`define RSI_ADDR_TB       5'h05
`define RSI_ADDR_TMRC     5'h06
`define RSI_ADDR_TMRD     5'h07
`define RSI_ADDR_MODE     5'h08
`define RSI_ADDR_IRQS     5'h09
`define RSI_ADDR_IRQM     5'h0a
`define RSI_ADDR_PDIR0    5'h10
`define RSI_ADDR_PDAT0    5'h18

`define RSI_BIT_TO        5
`define RSI_BIT_PDF       4
`define RSI_BIT_TMR_EN    0

`define RSI_ZERO8         8'h00
`define RSI_ONES8         8'hff
`define RSI_PC_RST        8'h00
`define RSI_SP_TOP        4'h0
`define RSI_WDT_LAST      8'hff

`define RSI_MODE_NORMAL   2'h0
`define RSI_MODE_SLOW     2'h1
`define RSI_MODE_IDLE     2'h2
`define RSI_MODE_SLEEP    2'h3

`define RSI_EV_PIN        0
`define RSI_EV_LVR        1
`define RSI_EV_WDTN       2
`define RSI_EV_WDTL       3
`define RSI_NEV           4

`endif

// file: src/rsi_pkg.sv
// types of the reset-state initializer
// assumes rsi_defs.svh for numeric constants
package rsi_pkg;
    typedef enum logic [3:0] {
        RSI_NORMAL = 4'b0001,
        RSI_SLOW   = 4'b0010,
        RSI_IDLE   = 4'b0100,
        RSI_SLEEP  = 4'b1000
    } rsi_mode_type;
endpackage

// file: src/rsi_sync.sv
// three-stage synchroniser with agreement filter
// assumes an asynchronous input level
`timescale 1ns/1ns
`default_nettype none
module rsi_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // level in and out
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // output moves only when the last two stages agree
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST_VAL;
        end else if (s2_q == s3_q) begin
            q_o <= s3_q;
        end
    end
endmodule
`default_nettype wire

// file: src/rsi_flags.sv
// timeout and power-down flags of the status register
// assumes single-cycle event strobes from the same clock
`timescale 1ns/1ns
`default_nettype none
module rsi_flags (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // events
    input  wire logic wdt_norm_i,
    input  wire logic wdt_low_i,
    input  wire logic sleep_enter_i,
    input  wire logic wdt_clear_i,
    // flags
    output logic      timeout_flag_o,
    output logic      power_down_flag_o
);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timeout_flag_o    <= 1'b0; // see [R1]
            power_down_flag_o <= 1'b0;
        end else if (wdt_low_i) begin
            timeout_flag_o    <= 1'b1; // see [R4]
            power_down_flag_o <= 1'b1;
        end else if (wdt_norm_i) begin
            timeout_flag_o    <= 1'b1; // see [R3]
        end else if (sleep_enter_i) begin
            timeout_flag_o    <= 1'b0; // see [R5]
            power_down_flag_o <= 1'b1;
        end else if (wdt_clear_i) begin
            timeout_flag_o    <= 1'b0; // see [R5]
            power_down_flag_o <= 1'b0;
        end
    end

    a_wdt_low_both: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wdt_low_i |=> timeout_flag_o && power_down_flag_o) // see [R4]
        else $error("low-power watchdog did not set both flags");
    a_wdt_norm_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wdt_norm_i && !wdt_low_i |=> timeout_flag_o && $stable(power_down_flag_o)) // see [R3]
        else $error("running watchdog reset flag update wrong");
    a_idle_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!wdt_norm_i && !wdt_low_i && !sleep_enter_i && !wdt_clear_i)
        |=> $stable(timeout_flag_o) && $stable(power_down_flag_o)) // see [R2]
        else $error("flags changed without an event");
endmodule
`default_nettype wire

// file: src/rsi_top.sv
// reset-state initializer: reset causes, flag keeping, state init
// assumes pin and low-voltage inputs asynchronous, register port synchronous
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "rsi_defs.svh"
module rsi_top
    import rsi_pkg::*;
(
    // clock and power-on reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_n_i,
    // reset sources
    input  wire logic                          external_reset_pin_n_i,
    input  wire logic                          low_voltage_reset_i,
    // register port
    input  wire logic [`RSI_AW-1:0]            addr_i,
    input  wire logic [`RSI_DW-1:0]            wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [`RSI_DW-1:0]            rdata_o,
    // core state
    output logic                               core_reset_o,
    output logic      [`RSI_DW-1:0]            program_counter_low_o,
    output logic      [`RSI_SPW-1:0]           stack_ptr_o,
    output logic      [`RSI_DW-1:0]            int_enable_o,
    output logic                               timer_on_o,
    output rsi_mode_type                       mode_o,
    // ports, direction 1 is input
    output logic      [`RSI_NPORTS*`RSI_DW-1:0] port_a_direction_o,
    output logic      [`RSI_NPORTS*`RSI_DW-1:0] port_data_o,
    // flags and interrupt
    output logic                               timeout_flag_o,
    output logic                               power_down_flag_o,
    output logic                               irq_o
);
    logic                  pin_s;
    logic                  lvr_s;
    logic                  pin_rst;
    logic                  warm;
    logic                  low_power;
    logic                  wdt_fire;
    logic                  wdt_norm;
    logic                  wdt_low;
    logic                  full_init;
    logic                  wdt_clear;
    logic                  sleep_enter;
    logic                  pin_rst_q;
    logic                  lvr_q;
    logic [`RSI_DW-1:0]    pcl_q;
    logic [`RSI_SPW-1:0]   sp_q;
    logic [`RSI_DW-1:0]    inten_q;
    logic [`RSI_DW-1:0]    wdt_q;
    logic [`RSI_DW-1:0]    tb_q;
    logic [`RSI_DW-1:0]    tmrc_q;
    logic [`RSI_DW-1:0]    tmrd_q;
    rsi_mode_type          mode_q;
    logic [`RSI_NEV-1:0]   ev;
    logic [`RSI_NEV-1:0]   irqs_q;
    logic [`RSI_NEV-1:0]   irqm_q;
    logic [`RSI_DW-1:0]    dir_q [`RSI_NPORTS];
    logic [`RSI_DW-1:0]    dat_q [`RSI_NPORTS];
    logic [`RSI_DW-1:0]    rd_d;
    logic [`RSI_DW-1:0]    status;

    // reset sources cross into the clock domain
    rsi_sync #(.RST_VAL(1'b1)) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       (external_reset_pin_n_i),
        .q_o       (pin_s)
    );

    rsi_sync #(.RST_VAL(1'b0)) u_lvr_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .d_i       (low_voltage_reset_i),
        .q_o       (lvr_s)
    );

    // pin and low-voltage resets hold the core while asserted
    assign pin_rst     = !pin_s;
    assign warm        = pin_rst || lvr_s;
    assign low_power   = (mode_q == RSI_IDLE) || (mode_q == RSI_SLEEP);
    assign wdt_fire    = (wdt_q == `RSI_WDT_LAST);
    // a held pin or low-voltage reset masks a watchdog expiry
    assign wdt_norm    = wdt_fire && !low_power && !warm; // see [R2]
    assign wdt_low     = wdt_fire && low_power && !warm;
    // low-power watchdog reset is partial, the rest are full
    assign full_init   = warm || wdt_norm;
    assign wdt_clear   = wr_i && (addr_i == `RSI_ADDR_WDT) && !full_init && !wdt_low;
    assign sleep_enter = wr_i && (addr_i == `RSI_ADDR_MODE) && !full_init && !wdt_low
                         && wdata_i[1];

    rsi_flags u_flags (
        .clk_sys_i         (clk_sys_i),
        .rst_n_i           (rst_n_i),
        .wdt_norm_i        (wdt_norm),         // see [R3]
        .wdt_low_i         (wdt_low),          // see [R4]
        .sleep_enter_i     (sleep_enter),      // see [R5]
        .wdt_clear_i       (wdt_clear),
        .timeout_flag_o    (timeout_flag_o),
        .power_down_flag_o (power_down_flag_o)
    );

    // program counter low byte and stack pointer
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcl_q <= `RSI_PC_RST; // see [R6]
            sp_q  <= `RSI_SP_TOP;
        end else if (full_init || wdt_low) begin
            pcl_q <= `RSI_PC_RST; // see [R11] [R12]
            sp_q  <= `RSI_SP_TOP; // see [R12]
        end else if (wr_i && addr_i == `RSI_ADDR_PCL) begin
            pcl_q <= wdata_i;
        end else if (wr_i && addr_i == `RSI_ADDR_SP) begin
            sp_q  <= wdata_i[`RSI_SPW-1:0];
        end
    end

    // interrupt enables: kept on a low-power watchdog reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inten_q <= `RSI_ZERO8; // see [R7]
        end else if (full_init) begin
            inten_q <= `RSI_ZERO8; // see [R7]
        end else if (wr_i && addr_i == `RSI_ADDR_INTEN && !wdt_low) begin
            inten_q <= wdata_i;
        end
    end

    // watchdog keeps counting through idle and sleep
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdt_q <= `RSI_ZERO8; // see [R8]
        end else if (full_init || wdt_fire || wdt_clear) begin
            wdt_q <= `RSI_ZERO8; // see [R8]
        end else begin
            wdt_q <= wdt_q + 8'h01;
        end
    end

    // time base is free running
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tb_q <= `RSI_ZERO8; // see [R8]
        end else if (full_init) begin
            tb_q <= `RSI_ZERO8;
        end else begin
            tb_q <= tb_q + 8'h01;
        end
    end

    // timer module control and count
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmrc_q <= `RSI_ZERO8; // see [R9]
            tmrd_q <= `RSI_ZERO8;
        end else if (full_init) begin
            tmrc_q <= `RSI_ZERO8; // see [R9]
            tmrd_q <= `RSI_ZERO8;
        end else begin
            if (wr_i && addr_i == `RSI_ADDR_TMRC && !wdt_low) begin
                tmrc_q <= wdata_i;
            end
            if (tmrc_q[`RSI_BIT_TMR_EN]) begin
                tmrd_q <= tmrd_q + 8'h01;
            end
        end
    end

    // operating mode; any reset wakes the core to normal
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= RSI_NORMAL;
        end else if (full_init || wdt_low) begin
            mode_q <= RSI_NORMAL;
        end else if (wr_i && addr_i == `RSI_ADDR_MODE) begin
            if (wdata_i[1:0] == `RSI_MODE_SLOW) begin
                mode_q <= RSI_SLOW;
            end else if (wdata_i[1:0] == `RSI_MODE_IDLE) begin
                mode_q <= RSI_IDLE;
            end else if (wdata_i[1:0] == `RSI_MODE_SLEEP) begin
                mode_q <= RSI_SLEEP;
            end else begin
                mode_q <= RSI_NORMAL;
            end
        end
    end

    // port direction and data, all inputs after a full reset; kept on a low-power watchdog reset
    genvar p;
    generate
        for (p = 0; p < `RSI_NPORTS; p++) begin : g_port
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dir_q[p] <= `RSI_ONES8; // see [R10]
                    dat_q[p] <= `RSI_ONES8;
                end else if (full_init) begin
                    dir_q[p] <= `RSI_ONES8; // see [R10]
                    dat_q[p] <= `RSI_ONES8;
                end else if (wr_i && !wdt_low
                             && addr_i == `RSI_ADDR_PDIR0 + 5'(p)) begin
                    dir_q[p] <= wdata_i;
                end else if (wr_i && !wdt_low
                             && addr_i == `RSI_ADDR_PDAT0 + 5'(p)) begin
                    dat_q[p] <= wdata_i;
                end
            end
            // bit 0 drives out, bit 1 leaves the pin an input
            assign port_a_direction_o[p*`RSI_DW +: `RSI_DW] = dir_q[p]; // see [R13]
            assign port_data_o[p*`RSI_DW +: `RSI_DW]        = dat_q[p];
        end
    endgenerate

    // reset-cause events, rising edges only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_rst_q <= 1'b0;
            lvr_q     <= 1'b0;
        end else begin
            pin_rst_q <= pin_rst;
            lvr_q     <= lvr_s;
        end
    end

    always_comb begin
        ev                = '0;
        ev[`RSI_EV_PIN]   = pin_rst && !pin_rst_q;
        ev[`RSI_EV_LVR]   = lvr_s && !lvr_q;
        ev[`RSI_EV_WDTN]  = wdt_norm;
        ev[`RSI_EV_WDTL]  = wdt_low;
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irqs_q <= '0;
        end else if (wr_i && addr_i == `RSI_ADDR_IRQS) begin
            irqs_q <= (irqs_q & ~wdata_i[`RSI_NEV-1:0]) | ev;
        end else begin
            irqs_q <= irqs_q | ev;
        end
    end

    // mask survives pin, low-voltage and watchdog resets so software learns the cause afterwards
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irqm_q <= '0;
        end else if (wr_i && addr_i == `RSI_ADDR_IRQM) begin
            irqm_q <= wdata_i[`RSI_NEV-1:0];
        end
    end

    // status byte: other bits read zero
    always_comb begin
        status               = `RSI_ZERO8;
        status[`RSI_BIT_TO]  = timeout_flag_o;    // see [R14]
        status[`RSI_BIT_PDF] = power_down_flag_o; // see [R14]
    end

    always_comb begin
        rd_d = `RSI_ZERO8;
        if (addr_i == `RSI_ADDR_STATUS) begin
            rd_d = status;
        end else if (addr_i == `RSI_ADDR_PCL) begin
            rd_d = pcl_q;
        end else if (addr_i == `RSI_ADDR_SP) begin
            rd_d = {{(`RSI_DW-`RSI_SPW){1'b0}}, sp_q};
        end else if (addr_i == `RSI_ADDR_INTEN) begin
            rd_d = inten_q;
        end else if (addr_i == `RSI_ADDR_WDT) begin
            rd_d = wdt_q;
        end else if (addr_i == `RSI_ADDR_TB) begin
            rd_d = tb_q;
        end else if (addr_i == `RSI_ADDR_TMRC) begin
            rd_d = tmrc_q;
        end else if (addr_i == `RSI_ADDR_TMRD) begin
            rd_d = tmrd_q;
        end else if (addr_i == `RSI_ADDR_MODE) begin
            rd_d = {4'h0, mode_q};
        end else if (addr_i == `RSI_ADDR_IRQS) begin
            rd_d = {{(`RSI_DW-`RSI_NEV){1'b0}}, irqs_q};
        end else if (addr_i == `RSI_ADDR_IRQM) begin
            rd_d = {{(`RSI_DW-`RSI_NEV){1'b0}}, irqm_q};
        end else if (addr_i >= `RSI_ADDR_PDIR0
                     && addr_i < `RSI_ADDR_PDIR0 + 5'(`RSI_NPORTS)) begin
            rd_d = dir_q[addr_i[2:0]];
        end else if (addr_i >= `RSI_ADDR_PDAT0
                     && addr_i < `RSI_ADDR_PDAT0 + 5'(`RSI_NPORTS)) begin
            rd_d = dat_q[addr_i[2:0]];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `RSI_ZERO8;
        end else if (rd_i) begin
            rdata_o <= rd_d;
        end else begin
            rdata_o <= `RSI_ZERO8;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_reset_o <= 1'b1;
        end else begin
            core_reset_o <= full_init || wdt_low;
        end
    end

    assign program_counter_low_o = pcl_q;
    assign stack_ptr_o           = sp_q;
    assign int_enable_o          = inten_q;
    assign timer_on_o            = tmrc_q[`RSI_BIT_TMR_EN];
    assign mode_o                = mode_q;
    assign irq_o                 = |(irqs_q & irqm_q);

    a_warm_keeps_flags: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        warm |=> $stable(timeout_flag_o) && $stable(power_down_flag_o)) // see [R2]
        else $error("pin or low-voltage reset changed a flag");
    a_init_pc_sp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        full_init || wdt_low |=> pcl_q == `RSI_PC_RST && sp_q == `RSI_SP_TOP) // see [R6]
        else $error("counter or stack pointer not initialised");
    a_init_inten: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        full_init |=> inten_q == `RSI_ZERO8) // see [R7]
        else $error("interrupt enables left on after reset");
    a_wdt_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        full_init ##1 !full_init |=> wdt_q == 8'h01) // see [R8]
        else $error("watchdog did not restart after reset");
    a_init_timer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        full_init |=> !timer_on_o && tmrd_q == `RSI_ZERO8) // see [R9]
        else $error("timer not off after reset");
    a_init_ports: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        full_init |=> &port_a_direction_o && &port_data_o) // see [R10]
        else $error("ports not inputs after reset");
    a_low_keeps_ports: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wdt_low |=> $stable(port_a_direction_o) && $stable(inten_q)) // see [R11]
        else $error("low-power watchdog reset disturbed kept state");
    a_sleep_sets_pdf: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sleep_enter && !wdt_norm |=> power_down_flag_o && !timeout_flag_o) // see [R5]
        else $error("sleep entry flag update wrong");
    a_status_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_i && addr_i == `RSI_ADDR_STATUS
        |=> rdata_o[`RSI_BIT_TO] == $past(timeout_flag_o)
            && rdata_o[`RSI_BIT_PDF] == $past(power_down_flag_o)) // see [R14]
        else $error("status read shows wrong flag bits");
endmodule
`default_nettype wire

// file: sim/tb_rsi_top.sv
// self-checking bench of the reset-state initializer
// assumes the register map of rsi_defs.svh and a free-running watchdog
`timescale 1ns/1ns
`default_nettype none
`include "rsi_defs.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", what, exp, got); end end
module tb_rsi_top
    import rsi_pkg::*;
;
    logic                            clk_sys_i;
    logic                            rst_n_i;
    logic                            pin_n;
    logic                            low_voltage_reset;
    logic [`RSI_AW-1:0]              addr;
    logic [`RSI_DW-1:0]              wdata;
    logic                            wr;
    logic                            rd;
    logic [`RSI_DW-1:0]              rdata;
    logic                            core_rst;
    logic [`RSI_DW-1:0]              program_counter_low;
    logic [`RSI_SPW-1:0]             sp;
    logic [`RSI_DW-1:0]              inten;
    logic                            tmr_on;
    rsi_mode_type                    mode;
    logic [`RSI_NPORTS*`RSI_DW-1:0]  pdir;
    logic [`RSI_NPORTS*`RSI_DW-1:0]  pdat;
    logic                            to_flag;
    logic                            pd_flag;
    logic                            irq;
    int                              n_errors;
    int                              check_count;
    logic [`RSI_DW-1:0]              d;
    logic [`RSI_DW-1:0]              d2;

    rsi_top uut (
        .clk_sys_i              (clk_sys_i),
        .rst_n_i                (rst_n_i),
        .external_reset_pin_n_i (pin_n),
        .low_voltage_reset_i    (low_voltage_reset),
        .addr_i                 (addr),
        .wdata_i                (wdata),
        .wr_i                   (wr),
        .rd_i                   (rd),
        .rdata_o                (rdata),
        .core_reset_o           (core_rst),
        .program_counter_low_o  (program_counter_low),
        .stack_ptr_o            (sp),
        .int_enable_o           (inten),
        .timer_on_o             (tmr_on),
        .mode_o                 (mode),
        .port_a_direction_o     (pdir),
        .port_data_o            (pdat),
        .timeout_flag_o         (to_flag),
        .power_down_flag_o      (pd_flag),
        .irq_o                  (irq)
    );

    always #10 clk_sys_i = ~clk_sys_i;

    task automatic wr_reg(input logic [`RSI_AW-1:0] a, input logic [`RSI_DW-1:0] v);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
        // let the write settle before the caller looks at outputs
        @(negedge clk_sys_i);
    endtask

    task automatic rd_reg(input logic [`RSI_AW-1:0] a, output logic [`RSI_DW-1:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_i);
        rd   <= 1'b0;
        @(negedge clk_sys_i);
        v = rdata;
    endtask

    // watchdog expiry is internal, so wait on the core reset it causes
    task automatic wait_core_reset();
        int i;
        i = 0;
        while (core_rst !== 1'b1 && i < 300) begin
            @(negedge clk_sys_i);
            i++;
        end
        `CHK("core reset seen", 1'b1, core_rst)
        repeat (2) @(negedge clk_sys_i);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic t_power_on();
        rd_reg(`RSI_ADDR_STATUS, d);
        `CHK("status flags", 2'b00, d[`RSI_BIT_TO:`RSI_BIT_PDF])
        `CHK("pc", `RSI_PC_RST, program_counter_low)
        `CHK("sp", `RSI_SP_TOP, sp)
        `CHK("inten", `RSI_ZERO8, inten)
        `CHK("timer", 1'b0, tmr_on)
        `CHK("dir", {`RSI_NPORTS{`RSI_ONES8}}, pdir)
        `CHK("data", {`RSI_NPORTS{`RSI_ONES8}}, pdat)
        `CHK("irq", 1'b0, irq)
        rd_reg(5'h1f, d);
        `CHK("unmapped", `RSI_ZERO8, d)
    endtask

    // pin then low-voltage reset, each with the power-down flag set beforehand
    task automatic t_warm(input int src);
        wr_reg(`RSI_ADDR_WDT, 8'h00);
        wr_reg(`RSI_ADDR_MODE, 8'h03);
        `CHK("sleep sets pdf", 1'b1, pd_flag)
        wr_reg(`RSI_ADDR_MODE, 8'h00);
        wr_reg(`RSI_ADDR_PCL, 8'h5a);
        wr_reg(`RSI_ADDR_TMRC, 8'h01);
        wr_reg(`RSI_ADDR_PDIR0, 8'h00);
        `CHK("timer on", 1'b1, tmr_on)
        @(posedge clk_sys_i);
        if (src == 0) pin_n <= 1'b0;
        else low_voltage_reset <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        pin_n <= 1'b1;
        low_voltage_reset   <= 1'b0;
        repeat (8) @(negedge clk_sys_i);
        `CHK("warm to", 1'b0, to_flag)
        `CHK("warm pdf", 1'b1, pd_flag)
        `CHK("warm pc", `RSI_PC_RST, program_counter_low)
        `CHK("warm timer", 1'b0, tmr_on)
        `CHK("warm dir", `RSI_ONES8, pdir[7:0])
    endtask

    task automatic t_wdt_normal();
        wr_reg(`RSI_ADDR_WDT, 8'h00);
        `CHK("clear to", 1'b0, to_flag)
        wr_reg(`RSI_ADDR_MODE, 8'h03);
        wr_reg(`RSI_ADDR_MODE, 8'h00);
        wr_reg(`RSI_ADDR_PCL, 8'h5a);
        wr_reg(`RSI_ADDR_PDIR0, 8'h00);
        wait_core_reset();
        `CHK("wdn to", 1'b1, to_flag)
        `CHK("wdn pdf", 1'b1, pd_flag)
        `CHK("wdn pc", `RSI_PC_RST, program_counter_low)
        `CHK("wdn dir", `RSI_ONES8, pdir[7:0])
        rd_reg(`RSI_ADDR_WDT, d);
        rd_reg(`RSI_ADDR_WDT, d2);
        `CHK("wdt cleared", 1'b1, d < 8'h10)
        `CHK("wdt counting", 1'b1, d2 > d)
        rd_reg(`RSI_ADDR_TB, d);
        `CHK("time base cleared", 1'b1, d < 8'h10)
    endtask

    task automatic t_wdt_low();
        wr_reg(`RSI_ADDR_WDT, 8'h00);
        wr_reg(`RSI_ADDR_PCL, 8'h33);
        wr_reg(`RSI_ADDR_SP, 8'h07);
        wr_reg(`RSI_ADDR_INTEN, 8'h5a);
        wr_reg(`RSI_ADDR_PDIR0, 8'h0f);
        `CHK("sp written", 4'h7, sp)
        wr_reg(`RSI_ADDR_MODE, 8'h02);
        `CHK("idle pdf", 1'b1, pd_flag)
        `CHK("idle to", 1'b0, to_flag)
        wait_core_reset();
        `CHK("wdl to", 1'b1, to_flag)
        `CHK("wdl pdf", 1'b1, pd_flag)
        `CHK("wdl pc", `RSI_PC_RST, program_counter_low)
        `CHK("wdl sp", 4'h0, sp)
        `CHK("wdl inten", 8'h5a, inten)
        `CHK("wdl dir", 8'h0f, pdir[7:0])
        `CHK("wdl mode", RSI_NORMAL, mode)
    endtask

    task automatic t_irq();
        rd_reg(`RSI_ADDR_IRQS, d);
        `CHK("irq status", 8'h0f, d)
        `CHK("irq masked", 1'b0, irq)
        wr_reg(`RSI_ADDR_IRQM, 8'h08);
        @(negedge clk_sys_i);
        `CHK("irq up", 1'b1, irq)
        wr_reg(`RSI_ADDR_IRQS, 8'h08);
        @(negedge clk_sys_i);
        `CHK("irq cleared", 1'b0, irq)
        rd_reg(`RSI_ADDR_IRQS, d);
        `CHK("irq left", 8'h07, d)
    endtask

    initial begin
        clk_sys_i   = 1'b0;
        rst_n_i     = 1'b0;
        pin_n       = 1'b1;
        low_voltage_reset         = 1'b0;
        addr        = '0;
        wdata       = '0;
        wr          = 1'b0;
        rd          = 1'b0;
        n_errors    = 0;
        check_count = 0;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_power_on();
        t_warm(0);
        t_warm(1);
        t_wdt_normal();
        t_wdt_low();
        t_irq();
        close_out();
    end

    // whole run is well under a thousand cycles
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
